//--- hdl/tmb_pkg.sv
/*
  Package for the second timer block: register offsets, bit positions,
  reset values and prescale counts.
  Assumes a 32-bit APB slave port and a core clock equal to the oscillator.
*/
package tmb_pkg;
  // Register byte offsets
  localparam logic [7:0] TMB_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TMB_OFF_MODE   = 8'h04;
  localparam logic [7:0] TMB_OFF_RLD_LO = 8'h08;
  localparam logic [7:0] TMB_OFF_RLD_HI = 8'h0C;
  localparam logic [7:0] TMB_OFF_CNT_LO = 8'h10;
  localparam logic [7:0] TMB_OFF_CNT_HI = 8'h14;
  localparam logic [7:0] TMB_OFF_IE     = 8'h18;

  // Control register bits
  localparam int TMB_CTRL_OVF    = 7;
  localparam int TMB_CTRL_EXT    = 6;
  localparam int TMB_CTRL_RCLK   = 5;
  localparam int TMB_CTRL_TRANSMIT_CLOCK_SELECT   = 4;
  localparam int TMB_CTRL_EXEN   = 3;
  localparam int TMB_CTRL_RUN    = 2;
  localparam int TMB_CTRL_CT     = 1;
  localparam int TMB_CTRL_CAP    = 0;

  // Mode register bits
  localparam int TMB_MODE_CKOE   = 1;
  localparam int TMB_MODE_DCEN   = 0;

  // Interrupt enable register bits
  localparam int TMB_IE_GLOBAL   = 7;
  localparam int TMB_IE_RSVD     = 6;
  localparam int TMB_IE_TIMER2   = 5;
  localparam logic [7:0] TMB_IE_MASK = 8'hBF;

  // Reset values
  localparam logic [7:0]  TMB_CTRL_RST = 8'h00;
  localparam logic [1:0]  TMB_MODE_RST = 2'h0;
  localparam logic [15:0] TMB_CNT_RST  = 16'h0000;
  localparam logic [15:0] TMB_RLD_RST  = 16'h0000;
  localparam logic [7:0]  TMB_IE_RST   = 8'h00;

  // Prescale: state time is 2 oscillator clocks, machine cycle is 12
  localparam logic [3:0]  TMB_STATE_DIV   = 4'h2;
  localparam logic [3:0]  TMB_MACH_LAST   = 4'hB;
  localparam logic [15:0] TMB_CNT_TOP     = 16'hFFFF;
  localparam logic [3:0]  TMB_BAUD_LAST   = 4'hF;
endpackage

//--- hdl/tmb_timer_two.sv
/*
  Second 16-bit timer with baud rate generator and programmable clock out,
  its interrupt request and the interrupt enable register, on APB.
  Assumes sys_clk is the oscillator clock, pins arrive asynchronously,
  and the serial port consumes the one-cycle baud ticks.
*/
// Summary of operation
// R1 - Either transmit or receive clock select bit puts the timer in baud mode.
// R2 - Transmit and receive selects are separate, other direction may use timer one.
// R3 - In baud mode each rollover reloads the count from the reload pair.
// R4 - Serial bit rate is the overflow rate divided by sixteen.
// R5 - Baud mode timer counts every state time, not every machine cycle.
// R6 - Bit rate equals oscillator over 32 times 65536 minus reload.
// R7 - In baud mode rollover sets no overflow flag and raises no request.
// R8 - In baud mode trigger falling edge sets external flag without reload.
// R9 - Software leaves the count alone while the baud generator runs.
// R10 - Software does not write the reload pair while the generator runs.
// R11 - Clock output mode drives a 50% duty clock on the output pin.
// R12 - Clock output needs counter select clear and output enable set.
// R13 - Run control bit starts and stops the timer.
// R14 - Clock out equals oscillator over 4 times 65536 minus reload.
// R15 - In clock output mode rollovers raise no interrupt request.
// R16 - Baud generation and clock output run together from one reload pair.
// R17 - Timer request is the OR of overflow and external flags.
// R18 - Hardware never clears either flag; software clears them.
// R19 - Overflow flag is set in the very cycle of the overflow.
// R20 - Enable register holds one enable per source, bits five to zero.
// R21 - Global enable clear blocks every request; set lets each enable decide.
// R22 - Software never writes ones to enable bit six.
// R23 - Clock output toggles on every rollover, counting at half oscillator rate.
`timescale 1ns/100ps
module tmb_timer_two (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        external_trigger_pin,
  input  wire logic        clock_output_pin_i,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_n,
  // Serial port timing
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  output logic             transmit_clock_select,
  output logic             receive_clock_select,
  // Interrupts
  output logic             timer_two_irq,
  output logic [7:0]       interrupt_enable_reg
);
  import tmb_pkg::*;

  logic [7:0]  timer_control_reg_r;
  logic [1:0]  timer_mode_reg_r;
  logic [15:0] cnt_r;
  logic [15:0] rld_r;
  logic [7:0]  ie_r;
  logic [3:0]  presc_r;
  logic [3:0]  baud_div_r;
  logic [2:0]  trig_sync_r;
  logic [2:0]  cpin_sync_r;
  logic        apb_wr;
  logic        apb_setup;
  logic        state_tick;
  logic        mach_tick;
  logic        trig_fall;
  logic        cpin_fall;
  logic        baud_mode;
  logic        clkout_mode;
  logic        run;
  logic        inc;
  logic        roll;
  logic        ext_evt;
  logic        wr_ctrl;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_rld_lo;
  logic        wr_rld_hi;
  logic [31:0] rd_nxt;
  logic        err_nxt;
  logic        ovf16;

  // Mode decode
  assign run         = timer_control_reg_r[TMB_CTRL_RUN];
  assign baud_mode   = timer_control_reg_r[TMB_CTRL_RCLK] | timer_control_reg_r[TMB_CTRL_TRANSMIT_CLOCK_SELECT]; // R1
  assign clkout_mode = timer_mode_reg_r[TMB_MODE_CKOE] & ~timer_control_reg_r[TMB_CTRL_CT];    // R12

  // APB decode
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite & clk_en;
  assign wr_ctrl   = apb_wr & (paddr == TMB_OFF_CTRL);
  assign wr_cnt_lo = apb_wr & (paddr == TMB_OFF_CNT_LO);
  assign wr_cnt_hi = apb_wr & (paddr == TMB_OFF_CNT_HI);
  assign wr_rld_lo = apb_wr & (paddr == TMB_OFF_RLD_LO);
  assign wr_rld_hi = apb_wr & (paddr == TMB_OFF_RLD_HI);

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == TMB_OFF_CTRL) begin
      rd_nxt[7:0] = timer_control_reg_r;
    end else if (paddr == TMB_OFF_MODE) begin
      rd_nxt[1:0] = timer_mode_reg_r;
    end else if (paddr == TMB_OFF_RLD_LO) begin
      rd_nxt[7:0] = rld_r[7:0];
    end else if (paddr == TMB_OFF_RLD_HI) begin
      rd_nxt[7:0] = rld_r[15:8];
    end else if (paddr == TMB_OFF_CNT_LO) begin
      rd_nxt[7:0] = cnt_r[7:0];
    end else if (paddr == TMB_OFF_CNT_HI) begin
      rd_nxt[7:0] = cnt_r[15:8];
    end else if (paddr == TMB_OFF_IE) begin
      rd_nxt[7:0] = ie_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // APB answer: ready in the cycle after setup
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (apb_setup) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr <= err_nxt;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Pin synchronisers with a third stage for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_sync_r <= 3'h7;
      cpin_sync_r <= 3'h7;
    end else if (clk_en) begin
      trig_sync_r <= {trig_sync_r[1:0], external_trigger_pin};
      cpin_sync_r <= {cpin_sync_r[1:0], clock_output_pin_i};
    end
  end
  assign trig_fall = trig_sync_r[2] & ~trig_sync_r[1];
  assign cpin_fall = cpin_sync_r[2] & ~cpin_sync_r[1] & ~clkout_mode;
  assign ext_evt   = trig_fall & timer_control_reg_r[TMB_CTRL_EXEN];

  // Oscillator prescale: state time and machine cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      presc_r <= 4'h0;
    end else if (clk_en) begin
      presc_r <= (presc_r == TMB_MACH_LAST) ? 4'h0 : 4'(presc_r + 4'h1);
    end
  end
  assign state_tick = (presc_r[0] == TMB_STATE_DIV[1]);
  assign mach_tick  = (presc_r == TMB_MACH_LAST);

  // Count source selection
  always_comb begin
    inc = 1'b0;
    if (run) begin // R13
      if (timer_control_reg_r[TMB_CTRL_CT]) begin
        inc = cpin_fall;
      end else if (baud_mode | clkout_mode) begin
        inc = state_tick; // R5 R23
      end else begin
        inc = mach_tick;
      end
    end
  end
  assign roll = inc & (cnt_r == TMB_CNT_TOP);

  // Counter: rollover reload, trigger reload and software writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= TMB_CNT_RST;
    end else if (clk_en) begin
      if (wr_cnt_lo | wr_cnt_hi) begin
        if (wr_cnt_lo) begin
          cnt_r[7:0] <= pwdata[7:0];
        end
        if (wr_cnt_hi) begin
          cnt_r[15:8] <= pwdata[7:0];
        end
      end else if (roll & (baud_mode | clkout_mode | ~timer_control_reg_r[TMB_CTRL_CAP])) begin
        cnt_r <= rld_r; // R3 R16
      end else if (ext_evt & ~baud_mode & ~timer_control_reg_r[TMB_CTRL_CAP]) begin
        cnt_r <= rld_r; // R8
      end else if (inc) begin
        cnt_r <= 16'(cnt_r + 16'h0001);
      end
    end
  end

  // Reload pair: software preset, capture outside baud mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rld_r <= TMB_RLD_RST;
    end else if (clk_en) begin
      if (wr_rld_lo | wr_rld_hi) begin
        if (wr_rld_lo) begin
          rld_r[7:0] <= pwdata[7:0];
        end
        if (wr_rld_hi) begin
          rld_r[15:8] <= pwdata[7:0];
        end
      end else if (ext_evt & ~baud_mode & timer_control_reg_r[TMB_CTRL_CAP]) begin
        rld_r <= cnt_r;
      end
    end
  end

  // Control register with sticky flags, hardware set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timer_control_reg_r <= TMB_CTRL_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        timer_control_reg_r <= pwdata[7:0];
      end
      if (roll & ~baud_mode & ~clkout_mode) begin
        timer_control_reg_r[TMB_CTRL_OVF] <= 1'b1; // R7 R15 R19
      end
      if (ext_evt) begin
        timer_control_reg_r[TMB_CTRL_EXT] <= 1'b1; // R8 R18
      end
    end
  end

  // Mode and interrupt enable registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timer_mode_reg_r <= TMB_MODE_RST;
      ie_r             <= TMB_IE_RST;
    end else if (clk_en) begin
      if (apb_wr & (paddr == TMB_OFF_MODE)) begin
        timer_mode_reg_r <= pwdata[1:0];
      end
      if (apb_wr & (paddr == TMB_OFF_IE)) begin
        ie_r <= pwdata[7:0] & TMB_IE_MASK; // R20 R22
      end
    end
  end

  // Overflows divided by sixteen for serial modes 1 and 3
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      baud_div_r <= 4'h0;
    end else if (clk_en & roll & baud_mode) begin
      baud_div_r <= 4'(baud_div_r + 4'h1); // R4 R6
    end
  end
  assign ovf16 = roll & baud_mode & (baud_div_r == TMB_BAUD_LAST);

  // Serial timing outputs, each direction selected on its own
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_baud_tick          <= 1'b0;
      rx_baud_tick          <= 1'b0;
      transmit_clock_select <= 1'b0;
      receive_clock_select  <= 1'b0;
    end else if (clk_en) begin
      tx_baud_tick          <= ovf16 & timer_control_reg_r[TMB_CTRL_TRANSMIT_CLOCK_SELECT]; // R2
      rx_baud_tick          <= ovf16 & timer_control_reg_r[TMB_CTRL_RCLK]; // R2
      transmit_clock_select <= timer_control_reg_r[TMB_CTRL_TRANSMIT_CLOCK_SELECT];
      receive_clock_select  <= timer_control_reg_r[TMB_CTRL_RCLK];
    end
  end

  // Clock output pin, toggled on every rollover
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_output_pin_o    <= 1'b1;
      clock_output_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      clock_output_pin_oe_n <= ~clkout_mode; // R11 R12
      if (!clkout_mode) begin
        clock_output_pin_o <= 1'b1;
      end else if (roll) begin
        clock_output_pin_o <= ~clock_output_pin_o; // R14 R23
      end
    end
  end

  // Interrupt request and enable outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timer_two_irq        <= 1'b0;
      interrupt_enable_reg <= TMB_IE_RST;
    end else if (clk_en) begin
      timer_two_irq <= ie_r[TMB_IE_GLOBAL] & ie_r[TMB_IE_TIMER2] &
                       (timer_control_reg_r[TMB_CTRL_OVF] | timer_control_reg_r[TMB_CTRL_EXT]); // R17 R21
      interrupt_enable_reg <= ie_r[TMB_IE_GLOBAL] ? ie_r : TMB_IE_RST; // R21
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_BAUD_NO_OVF_FLAG: assert property ( // R7
    (clk_en && roll && baud_mode && !wr_ctrl) |=> timer_control_reg_r[TMB_CTRL_OVF] == $past(timer_control_reg_r[TMB_CTRL_OVF]))
    else $error("overflow flag changed on a baud mode rollover");

  AST_BAUD_RELOAD: assert property ( // R3
    (clk_en && roll && baud_mode && !wr_cnt_lo && !wr_cnt_hi && !wr_rld_lo && !wr_rld_hi) |=> cnt_r == $past(rld_r))
    else $error("baud mode rollover did not reload the count");

  AST_STATE_TIME_STEP: assert property ( // R5
    (clk_en && run && baud_mode && !timer_control_reg_r[TMB_CTRL_CT] && !wr_cnt_lo && !wr_cnt_hi && !roll)
      ##1 (clk_en && run && baud_mode && !timer_control_reg_r[TMB_CTRL_CT] && !wr_cnt_lo && !wr_cnt_hi && !roll)
      |=> cnt_r == 16'($past(cnt_r, 2) + 16'h0001))
    else $error("baud mode count did not advance once per state time");

  AST_BAUD_EXT_NO_RELOAD: assert property ( // R8
    (clk_en && baud_mode && ext_evt && !roll && !wr_cnt_lo && !wr_cnt_hi)
      |=> timer_control_reg_r[TMB_CTRL_EXT] && cnt_r == 16'($past(cnt_r) + 16'($past(inc))))
    else $error("trigger edge in baud mode reloaded or missed its flag");

  AST_CLKOUT_TOGGLE: assert property ( // R23
    (clk_en && roll && clkout_mode && !(apb_wr && (paddr == TMB_OFF_MODE || paddr == TMB_OFF_CTRL)))
      |=> clock_output_pin_o != $past(clock_output_pin_o) && !clock_output_pin_oe_n)
    else $error("clock output did not toggle on rollover");

  AST_CLKOUT_NO_FLAG: assert property ( // R15
    (clk_en && roll && clkout_mode && !timer_control_reg_r[TMB_CTRL_OVF] && !wr_ctrl)
      |=> !timer_control_reg_r[TMB_CTRL_OVF])
    else $error("clock output rollover set the overflow flag");

  AST_IRQ_OR: assert property ( // R17
    clk_en |=> timer_two_irq == $past(ie_r[TMB_IE_GLOBAL] && ie_r[TMB_IE_TIMER2] &&
      (timer_control_reg_r[TMB_CTRL_OVF] || timer_control_reg_r[TMB_CTRL_EXT])))
    else $error("timer request is not the gated OR of its flags");

  AST_GLOBAL_OFF: assert property ( // R21
    (clk_en && !ie_r[TMB_IE_GLOBAL]) |=> !timer_two_irq && interrupt_enable_reg == TMB_IE_RST)
    else $error("request passed with the global enable clear");

  AST_FLAGS_STICKY: assert property ( // R18
    (clk_en && timer_control_reg_r[TMB_CTRL_OVF] && !wr_ctrl) |=> timer_control_reg_r[TMB_CTRL_OVF])
    else $error("hardware cleared the overflow flag");

  AST_OVF_SAME_CYCLE: assert property ( // R19
    (clk_en && roll && !baud_mode && !clkout_mode) |=> timer_control_reg_r[TMB_CTRL_OVF])
    else $error("overflow flag not set at the overflow");

  AST_RUN_STOP: assert property ( // R13
    (clk_en && !run && !wr_cnt_lo && !wr_cnt_hi && !ext_evt) |=> cnt_r == $past(cnt_r))
    else $error("count moved while stopped");

  AST_PIN_RELEASED: assert property ( // R11
    (clk_en && !clkout_mode) |=> clock_output_pin_oe_n)
    else $error("pin driven outside clock output mode");

  AST_IE_BIT6: assert property ( // R20
    ie_r[TMB_IE_RSVD] == 1'b0)
    else $error("reserved enable bit set");

  AST_BAUD_DIV16: assert property ( // R4
    (clk_en && tx_baud_tick) |-> $past(baud_div_r) == TMB_BAUD_LAST)
    else $error("transmit tick not on the sixteenth overflow");
endmodule

//--- sim/tmb_serial_model.sv
/*
  Serial port timing model that consumes the timer's baud ticks.
  Assumes one-cycle ticks on sys_clk and select levels from the timer.
*/
`timescale 1ns/100ps
module tmb_serial_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Baud timing from the timer
  input  wire logic        tx_baud_tick,
  input  wire logic        rx_baud_tick,
  input  wire logic        transmit_clock_select,
  input  wire logic        receive_clock_select,
  // Bit counts and tick spacing seen by the port
  output logic      [15:0] tx_bits,
  output logic      [15:0] rx_bits,
  output logic      [15:0] tx_gap,
  output logic      [15:0] rx_gap
);
  logic [15:0] cyc_r;
  logic [15:0] tx_last_r;
  logic [15:0] rx_last_r;

  // Free cycle counter for spacing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc_r <= 16'h0000;
    end else begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  // Transmit side shifts one bit per tick when it takes this timer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_bits   <= 16'h0000;
      tx_gap    <= 16'h0000;
      tx_last_r <= 16'h0000;
    end else if (tx_baud_tick && transmit_clock_select) begin
      tx_bits   <= tx_bits + 16'h0001;
      tx_gap    <= cyc_r - tx_last_r;
      tx_last_r <= cyc_r;
    end
  end

  // Receive side samples one bit per tick when it takes this timer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_bits   <= 16'h0000;
      rx_gap    <= 16'h0000;
      rx_last_r <= 16'h0000;
    end else if (rx_baud_tick && receive_clock_select) begin
      rx_bits   <= rx_bits + 16'h0001;
      rx_gap    <= cyc_r - rx_last_r;
      rx_last_r <= cyc_r;
    end
  end
endmodule

//--- sim/timer_two_baud_and_clock_out_tb_top.sv
/*
  Testbench for the second timer: APB register tasks and directed scenarios.
  Assumes a 40 MHz sys_clk and the serial timing model on the baud ticks.
*/
`timescale 1ns/100ps
module timer_two_baud_and_clock_out_tb_top;
  import tmb_pkg::*;
  localparam logic [15:0] RLD      = 16'hFFFE;
  localparam logic [31:0] OVF_CYC  = 2 * (65536 - int'(RLD));
  localparam logic [31:0] BAUD_CYC = 16 * OVF_CYC;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        external_trigger_pin = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_o;
  logic        pin_oe_n;
  logic        tx_tick;
  logic        rx_tick;
  logic        tx_sel;
  logic        rx_sel;
  logic        irq;
  logic [7:0]  ie_out;
  logic [15:0] tx_bits;
  logic [15:0] rx_bits;
  logic [15:0] tx_gap;
  logic [15:0] rx_gap;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  ctl;
  logic [15:0] b0;
  logic [7:0]  offs [7];
  int          bad_count = 0;
  int          n_tests = 0;
  int          h1;
  int          h2;

  always #12.5 sys_clk = ~sys_clk;

  tmb_timer_two i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(external_trigger_pin), .clock_output_pin_i(1'b1),
    .clock_output_pin_o(pin_o), .clock_output_pin_oe_n(pin_oe_n),
    .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick),
    .transmit_clock_select(tx_sel), .receive_clock_select(rx_sel),
    .timer_two_irq(irq), .interrupt_enable_reg(ie_out)
  );

  tmb_serial_model i_serial (
    .sys_clk(sys_clk), .rst_n(rst_n), .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick),
    .transmit_clock_select(tx_sel), .receive_clock_select(rx_sel),
    .tx_bits(tx_bits), .rx_bits(rx_bits), .tx_gap(tx_gap), .rx_gap(rx_gap)
  );

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      bad_count++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Lengths of two successive pin levels, in cycles
  task automatic pin_halves(output int ha, output int hb);
    logic p;
    int   k;
    p = pin_o;
    for (k = 0; k < 50 && pin_o === p; k++) @(posedge sys_clk);
    p = pin_o;
    for (ha = 0; ha < 50 && pin_o === p; ha++) @(posedge sys_clk);
    p = pin_o;
    for (hb = 0; hb < 50 && pin_o === p; hb++) @(posedge sys_clk);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    final_report;
  end

  initial begin
    offs = '{TMB_OFF_CTRL, TMB_OFF_MODE, TMB_OFF_RLD_LO, TMB_OFF_RLD_HI, TMB_OFF_CNT_LO, TMB_OFF_CNT_HI, TMB_OFF_IE};
    cycles(10);
    rst_n <= 1'b1;
    foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
    chk_bit(pin_oe_n, 1'b1);
    chk_bit(pin_o, 1'b1);
    // Unmapped address
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk_bit(err, 1'b1);
    chk(rd, 32'h0000_0000);
    // Enable register and global gate
    wr(TMB_OFF_IE, 8'hBF);
    rdc(TMB_OFF_IE, 32'h0000_00BF);
    cycles(2);
    chk({24'h00_0000, ie_out}, 32'h0000_00BF);
    wr(TMB_OFF_IE, 8'h3F);
    cycles(2);
    chk({24'h00_0000, ie_out}, 32'h0000_0000);
    wr(TMB_OFF_IE, 8'hA0);
    // Baud generation with clock out, each direction in turn
    wr(TMB_OFF_RLD_LO, RLD[7:0]);
    wr(TMB_OFF_RLD_HI, RLD[15:8]);
    wr(TMB_OFF_MODE, 8'h02);
    for (int i = 0; i < 2; i++) begin
      ctl = (i == 0) ? 8'h14 : 8'h24;
      wr(TMB_OFF_CNT_LO, RLD[7:0]);
      wr(TMB_OFF_CNT_HI, RLD[15:8]);
      b0 = (i == 0) ? rx_bits : tx_bits;
      wr(TMB_OFF_CTRL, ctl);
      cycles(300);
      chk({16'h0000, (i == 0) ? tx_gap : rx_gap}, BAUD_CYC);
      chk({16'h0000, (i == 0) ? rx_bits : tx_bits}, {16'h0000, b0});
      chk({30'h0, tx_sel, rx_sel}, (i == 0) ? 32'h0000_0002 : 32'h0000_0001);
      pin_halves(h1, h2);
      chk(32'(h1), OVF_CYC);
      chk(32'(h2), OVF_CYC);
      chk_bit(pin_oe_n, 1'b0);
      rdc(TMB_OFF_CTRL, {24'h00_0000, ctl});
      chk_bit(irq, 1'b0);
      wr(TMB_OFF_CTRL, 8'h00);
    end
    // Trigger pin in baud mode
    wr(TMB_OFF_CTRL, 8'h1C);
    cycles(20);
    external_trigger_pin <= 1'b0;
    cycles(10);
    rdc(TMB_OFF_CTRL, 32'h0000_005C);
    cycles(2);
    chk_bit(irq, 1'b1);
    cycles(300);
    chk({16'h0000, tx_gap}, BAUD_CYC);
    rdc(TMB_OFF_CTRL, 32'h0000_005C);
    wr(TMB_OFF_IE, 8'h20);
    cycles(3);
    chk_bit(irq, 1'b0);
    chk({24'h00_0000, ie_out}, 32'h0000_0000);
    external_trigger_pin <= 1'b1;
    wr(TMB_OFF_CTRL, 8'h00);
    rdc(TMB_OFF_CTRL, 32'h0000_0000);
    // Counter select blocks clock out
    wr(TMB_OFF_CTRL, 8'h06);
    cycles(3);
    chk_bit(pin_oe_n, 1'b1);
    wr(TMB_OFF_CTRL, 8'h00);
    // Plain timer overflow sets the flag and the request
    wr(TMB_OFF_MODE, 8'h00);
    wr(TMB_OFF_IE, 8'hA0);
    wr(TMB_OFF_CNT_LO, 8'hFF);
    wr(TMB_OFF_CNT_HI, 8'hFF);
    wr(TMB_OFF_CTRL, 8'h04);
    cycles(40);
    rdc(TMB_OFF_CTRL, 32'h0000_0084);
    chk_bit(irq, 1'b1);
    wr(TMB_OFF_CTRL, 8'h00);
    apb(1'b0, TMB_OFF_CNT_LO, 32'h0000_0000);
    b0 = rd[15:0];
    cycles(40);
    rdc(TMB_OFF_CNT_LO, {16'h0000, b0});
    final_report;
  end
endmodule
